// >>> bench/fpk_monitor.sv
module fpk_monitor (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [2:0] fixed_key_i,
  input wire logic [11:0] user_key_i,
  input wire logic [23:0] key_mode_i,
  input wire logic log_enable_i,
  input wire logic [2:0] fixed_key_active_flag_o,
  input wire logic [11:0] key_on_flag_o,
  input wire logic [11:0] key_off_flag_o,
  input wire logic [11:0] key_led_o,
  input wire fpk_pkg::fpk_event_t event_o,
  input wire fpk_pkg::fpk_msg_t msg_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import fpk_pkg::*;
  logic [11:0] dis_m;
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      dis_m[i] = key_mode_i[2*i+1] ~^ key_mode_i[2*i];
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  sequence fixed_take;
    $onehot(fixed_key_i) && user_key_i == 0 && $past(fixed_key_i == 0 && user_key_i == 0);
  endsequence
  chk_led_follow: assert property (key_led_o == key_on_flag_o) else $error("LED off its flag");
  chk_dis_low: assert property (((key_on_flag_o | key_off_flag_o) & dis_m) == 0) else $error("disabled flag");
  chk_off_compl: assert property (((key_on_flag_o ^ key_off_flag_o) | dis_m) == '1) else $error("off flag");
  chk_fixed_follow: assert property (fixed_take |=> (fixed_key_active_flag_o & $past(fixed_key_i)) != 0)
    else $error("fixed press lost");
  chk_fixed_hold: assert property ($fell(fixed_key_i[0]) && $past(fixed_key_active_flag_o[0]) |->
    fixed_key_active_flag_o[0] [*8]) else $error("fixed hold short");
  chk_fixed_log: assert property (fixed_take and log_enable_i |-> ##[1:2] event_o.valid && !event_o.is_user)
    else $error("fixed event missing");
  chk_two_keys: assert property ($rose(fixed_key_i[1]) && fixed_key_i[0] && !fixed_key_active_flag_o[1] |=>
    !fixed_key_active_flag_o[1]) else $error("second key taken");
  chk_mom_press: assert property (user_key_i == 12'h010 && fixed_key_i == 0 && key_mode_i[9:8] == FPK_MOMENTARY
    && $past(user_key_i == 0 && fixed_key_i == 0) |=> key_on_flag_o[4]) else $error("momentary press lost");
  chk_msg_show: assert property ($rose(key_on_flag_o[4]) |-> ##[0:3] msg_o.active && msg_o.key == 4'h4)
    else $error("message missing");
endmodule // fpk_monitor
bind fpk_pushbutton fpk_monitor fpk_monitor_inst (.clk_sys_i, .resetn_i, .fixed_key_i, .user_key_i, .key_mode_i,
  .log_enable_i, .fixed_key_active_flag_o, .key_on_flag_o, .key_off_flag_o, .key_led_o, .event_o, .msg_o);

// >>> bench/fpk_operator.sv
module fpk_operator (
  input wire logic [4:0] key_sel_i,
  input wire logic chord_i,
  output logic [2:0] fixed_key_o,
  output logic [11:0] user_key_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // One finger at a time; only the chord input puts two keys down together.
  always_comb begin
    {user_key_o, fixed_key_o} = 15'h0001 << key_sel_i;
    fixed_key_o[0] = fixed_key_o[0] | chord_i;
  end
endmodule // fpk_operator

// >>> bench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fpk_pkg::*;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [4:0] key_sel = 5'h0f;
  logic chord = 1'b0;
  logic [2:0] fixed_key_i, fixed_key_active_flag_o;
  logic [11:0] user_key_i, key_on_flag_o, key_off_flag_o, key_led_o, tog, en, e;
  logic [23:0] key_mode_i = '0;
  logic [191:0] key_release_hold_i = '0;
  logic [15:0] popup_ms_i = 16'h0064;
  logic log_enable_i = 1'b1;
  fpk_nv_t nv_restore_i = '{valid: 12'h004, state: 12'h004};
  fpk_nv_t nv_save_o;
  fpk_event_t event_o;
  fpk_msg_t msg_o;
  int error_cnt = 0;
  int comparisons = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  fpk_operator fpk_operator_inst (.key_sel_i(key_sel), .chord_i(chord), .fixed_key_o(fixed_key_i),
    .user_key_o(user_key_i));
  fpk_pushbutton fpk_pushbutton_inst (.clk_sys_i, .resetn_i, .fixed_key_i, .user_key_i, .key_mode_i,
    .key_release_hold_i, .popup_ms_i, .log_enable_i, .nv_restore_i, .nv_save_o, .fixed_key_active_flag_o,
    .key_on_flag_o, .key_off_flag_o, .key_led_o, .event_o, .msg_o);
  function automatic logic [11:0] exp_on(input logic [11:0] p);
    for (int i = 0; i < 12; i++) begin
      exp_on[i] = key_mode_i[2*i+:2] == FPK_MOMENTARY ? p[i] : key_mode_i[2*i+:2] == FPK_TOGGLE && tog[i];
    end
  endfunction
  task automatic complete_run;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Events trail the flag, so poll a few cycles rather than trust one latency.
  task automatic wait_evt(input logic u, input int k, input logic s);
    int n;
    for (n = 0; n < 6; n++) begin
      if (event_o.valid === 1'b1 && event_o.is_user === u && event_o.key === 4'(k)) break;
      @(negedge clk_sys_i);
    end
    cmp(12'(event_o.state), 12'(s));
    if (n == 6) begin
      error_cnt++;
      complete_run();
    end
  endtask
  initial begin
    int k;
    int n;
    void'($urandom(72));
    for (int i = 0; i < 12; i++) begin
      key_mode_i[2*i+:2] = 2'($urandom_range(2, 0));
    end
    key_mode_i[1:0] = 2'h3;
    key_mode_i[5:4] = FPK_TOGGLE;
    key_mode_i[9:8] = FPK_MOMENTARY;
    for (int i = 0; i < 12; i++) begin
      en[i] = key_mode_i[2*i] ^ key_mode_i[2*i+1];
    end
    tog = 12'h004;
    repeat (8) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    cmp(key_on_flag_o, exp_on(12'h000));
    cmp(nv_save_o.state, tog);
    cmp(nv_save_o.valid, 12'hfff);
    key_sel = 5'h00;
    wait_evt(1'b0, 0, 1'b1);
    cmp(12'(fixed_key_active_flag_o), 12'h001);
    key_sel = 5'h0f;
    n = 0;
    repeat (20) begin
      @(negedge clk_sys_i);
      n += int'(event_o.valid === 1'b1);
    end
    cmp(12'(n), 12'h000);
    cmp(12'(fixed_key_active_flag_o), 12'h001);
    key_sel = 5'h01;
    chord = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    cmp(12'(fixed_key_active_flag_o[1]), 12'h000);
    key_sel = 5'h0f;
    chord = 1'b0;
    for (int j = 0; j < 30; j++) begin
      k = j < 3 ? 2 * j : $urandom_range(11, 0);
      @(negedge clk_sys_i);
      key_sel = 5'(k + 3);
      if (key_mode_i[2*k+:2] == FPK_TOGGLE) tog[k] = ~tog[k];
      @(negedge clk_sys_i);
      e = exp_on(12'h001 << k);
      cmp(key_on_flag_o, e);
      cmp(key_off_flag_o, ~e & en);
      cmp(key_led_o, e);
      if (en[k]) begin
        wait_evt(1'b1, k, e[k]);
        @(negedge clk_sys_i);
        cmp(12'({msg_o.active, msg_o.key, msg_o.show_off}), {6'h00, 1'b1, 4'(k), ~e[k]});
      end
      key_sel = 5'h0f;
      if (key_mode_i[2*k+:2] == FPK_MOMENTARY) begin
        wait_evt(1'b1, k, 1'b0);
        cmp(12'(msg_o.show_off), 12'h000);
      end
    end
    key_release_hold_i[79:64] = 16'h0002;
    popup_ms_i = 16'h0000;
    key_sel = 5'h07;
    repeat (2) @(negedge clk_sys_i);
    key_sel = 5'h0f;
    repeat (50) @(negedge clk_sys_i);
    cmp(key_led_o & 12'h010, 12'h010);
    cmp(12'(msg_o.active), 12'h000);
    complete_run();
  end
endmodule // testbench

// >>> verilog/fpk_hold.sv
`include "fpk_params.svh"
module fpk_hold (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic tick_i,
  input wire logic level_i,
  input wire logic [`FPK_HOLD_W-1:0] hold_ms_i,
  output logic out_o
);
  logic [`FPK_HOLD_W-1:0] cnt_reg;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= `FPK_HOLD_W'h0000;
    end else if (level_i) begin
      cnt_reg <= hold_ms_i;
    end else if (tick_i && cnt_reg != `FPK_HOLD_W'h0000) begin
      cnt_reg <= cnt_reg - `FPK_HOLD_W'h0001;
    end
  end
  // The hold starts from the release, so a press always counts as held.
  assign out_o = level_i || (cnt_reg != `FPK_HOLD_W'h0000);
endmodule // fpk_hold

// >>> verilog/fpk_params.svh
`ifndef FPK_PARAMS_SVH
`define FPK_PARAMS_SVH
`define FPK_CLK_HZ 100000000
`define FPK_TICK_MS 1
`define FPK_TICK_CYCLES ((`FPK_CLK_HZ / 1000) * `FPK_TICK_MS)
`define FPK_FIXED_HOLD_MS 100
`define FPK_NUM_FIXED 3
`define FPK_NUM_USER 12
`define FPK_NUM_KEYS 15
`define FPK_LINE_CHARS 20
`define FPK_HOLD_W 16
`define FPK_MODE_DISABLED 2'h0
`define FPK_MODE_MOMENTARY 2'h1
`define FPK_MODE_TOGGLE 2'h2
`endif

// >>> verilog/fpk_pkg.sv
`include "fpk_params.svh"
package fpk_pkg;
  typedef enum logic [1:0] {
    FPK_DISABLED = `FPK_MODE_DISABLED,
    FPK_MOMENTARY = `FPK_MODE_MOMENTARY,
    FPK_TOGGLE = `FPK_MODE_TOGGLE
  } fpk_mode_t;
  typedef struct packed {
    logic valid;
    logic is_user;
    logic [3:0] key;
    logic state;
  } fpk_event_t;
  typedef struct packed {
    logic active;
    logic [3:0] key;
    logic show_off;
  } fpk_msg_t;
  typedef struct packed {
    logic [`FPK_NUM_USER-1:0] valid;
    logic [`FPK_NUM_USER-1:0] state;
  } fpk_nv_t;
endpackage

// >>> verilog/fpk_pushbutton.sv
`include "fpk_params.svh"
module fpk_pushbutton (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [`FPK_NUM_FIXED-1:0] fixed_key_i,
  input wire logic [`FPK_NUM_USER-1:0] user_key_i,
  input wire logic [`FPK_NUM_USER*2-1:0] key_mode_i,
  input wire logic [`FPK_NUM_USER*`FPK_HOLD_W-1:0] key_release_hold_i,
  input wire logic [`FPK_HOLD_W-1:0] popup_ms_i,
  input wire logic log_enable_i,
  input wire fpk_pkg::fpk_nv_t nv_restore_i,
  output fpk_pkg::fpk_nv_t nv_save_o,
  output logic [`FPK_NUM_FIXED-1:0] fixed_key_active_flag_o,
  output logic [`FPK_NUM_USER-1:0] key_on_flag_o,
  output logic [`FPK_NUM_USER-1:0] key_off_flag_o,
  output logic [`FPK_NUM_USER-1:0] key_led_o,
  output fpk_pkg::fpk_event_t event_o,
  output fpk_pkg::fpk_msg_t msg_o
);
  import fpk_pkg::*;

  localparam int unsigned FixedHoldCycles = `FPK_FIXED_HOLD_MS;
  localparam logic [`FPK_HOLD_W-1:0] FixedHold = `FPK_HOLD_W'(FixedHoldCycles);

  function automatic fpk_mode_t mode_of(input logic [`FPK_NUM_USER*2-1:0] m, input int idx);
    mode_of = fpk_mode_t'(m[idx*2 +: 2]);
  endfunction

  logic tick;
  fpk_tick u_tick (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .tick_o(tick)
  );

  // Only one key may be accepted at a time; the owner stays until it is released.
  logic [`FPK_NUM_KEYS-1:0] raw_keys;
  logic [`FPK_NUM_KEYS-1:0] owner_reg;
  logic [`FPK_NUM_KEYS-1:0] owner_next;
  logic [`FPK_NUM_KEYS-1:0] accepted;
  logic [`FPK_NUM_KEYS-1:0] press;
  assign raw_keys = {user_key_i, fixed_key_i};

  always_comb begin
    owner_next = owner_reg;
    if ((owner_reg & raw_keys) == '0) begin
      owner_next = '0;
      for (int i = 0; i < `FPK_NUM_KEYS; i++) begin
        if (raw_keys[i] && owner_next == '0 && (raw_keys & ~(`FPK_NUM_KEYS'(1) << i)) == '0) begin
          owner_next[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      owner_reg <= '0;
    end else begin
      owner_reg <= owner_next;
    end
  end

  assign accepted = owner_reg;
  assign press = owner_next & ~owner_reg;

  // Fixed keys need no password; they act on the accepted press directly.
  genvar g;
  generate
    for (g = 0; g < `FPK_NUM_FIXED; g++) begin : g_fixed
      fpk_hold u_hold (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .tick_i(tick),
        .level_i(accepted[g]),
        .hold_ms_i(FixedHold),
        .out_o(fixed_key_active_flag_o[g])
      );
    end
  endgenerate

  // Toggle state; restored from the nonvolatile copy just after reset release.
  logic [`FPK_NUM_USER-1:0] toggle_reg;
  logic [`FPK_NUM_USER-1:0] mom_on;
  logic restored_reg;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      restored_reg <= 1'b0;
    end else begin
      restored_reg <= 1'b1;
    end
  end

  generate
    for (g = 0; g < `FPK_NUM_USER; g++) begin : g_user
      always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
          toggle_reg[g] <= 1'b0;
        end else if (!restored_reg) begin
          toggle_reg[g] <= nv_restore_i.valid[g] & nv_restore_i.state[g];
        end else if (mode_of(key_mode_i, g) == FPK_TOGGLE && press[`FPK_NUM_FIXED+g]) begin
          toggle_reg[g] <= ~toggle_reg[g];
        end
      end

      fpk_hold u_hold (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .tick_i(tick),
        .level_i(accepted[`FPK_NUM_FIXED+g]),
        .hold_ms_i(key_release_hold_i[g*`FPK_HOLD_W +: `FPK_HOLD_W]),
        .out_o(mom_on[g])
      );

      always_comb begin
        case (mode_of(key_mode_i, g))
          FPK_MOMENTARY: begin
            key_on_flag_o[g] = mom_on[g];
            key_off_flag_o[g] = ~mom_on[g];
          end
          FPK_TOGGLE: begin
            key_on_flag_o[g] = toggle_reg[g];
            key_off_flag_o[g] = ~toggle_reg[g];
          end
          default: begin
            key_on_flag_o[g] = 1'b0;
            key_off_flag_o[g] = 1'b0;
          end
        endcase
      end
    end
  endgenerate

  assign key_led_o = key_on_flag_o;
  assign nv_save_o.valid = {`FPK_NUM_USER{restored_reg}};
  assign nv_save_o.state = toggle_reg;

  // Change detection on the user flags drives events and messages.
  logic [`FPK_NUM_USER-1:0] on_prev_reg;
  logic [`FPK_NUM_USER-1:0] rise;
  logic [`FPK_NUM_USER-1:0] toggle_fall;
  logic [`FPK_NUM_USER-1:0] changed;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      on_prev_reg <= '0;
    end else begin
      on_prev_reg <= key_on_flag_o;
    end
  end
  always_comb begin
    rise = key_on_flag_o & ~on_prev_reg;
    changed = key_on_flag_o ^ on_prev_reg;
    for (int i = 0; i < `FPK_NUM_USER; i++) begin
      toggle_fall[i] = on_prev_reg[i] & ~key_on_flag_o[i] & (mode_of(key_mode_i, i) == FPK_TOGGLE);
    end
  end

  // One event per cycle; a fixed-key press beats any user change, else the lowest numbered change wins. Keys are one at a time,
  // so collisions come from holds that expire together or with a press, and from toggle states restored after reset.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      event_o <= '0;
    end else begin
      event_o <= '0;
      if (log_enable_i && restored_reg) begin
        for (int i = `FPK_NUM_USER - 1; i >= 0; i--) begin
          if (changed[i]) begin
            event_o <= '{valid: 1'b1, is_user: 1'b1, key: 4'(i), state: key_on_flag_o[i]};
          end
        end
        for (int i = `FPK_NUM_FIXED - 1; i >= 0; i--) begin
          if (press[i]) begin
            event_o <= '{valid: 1'b1, is_user: 1'b0, key: 4'(i), state: 1'b1};
          end
        end
      end
    end
  end

  // Message selection and pop-up timer.
  logic [`FPK_HOLD_W-1:0] popup_reg;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      msg_o <= '0;
      popup_reg <= `FPK_HOLD_W'h0000;
    end else begin
      if (restored_reg && (rise != '0 || toggle_fall != '0)) begin
        for (int i = `FPK_NUM_USER - 1; i >= 0; i--) begin
          if (rise[i] || toggle_fall[i]) begin
            msg_o <= '{active: 1'b1, key: 4'(i), show_off: toggle_fall[i]};
          end
        end
        popup_reg <= popup_ms_i;
      end else if (popup_reg == `FPK_HOLD_W'h0000) begin
        msg_o.active <= 1'b0;
      end else if (tick) begin
        popup_reg <= popup_reg - `FPK_HOLD_W'h0001;
      end
    end
  end
endmodule // fpk_pushbutton

// >>> verilog/fpk_tick.sv
`include "fpk_params.svh"
module fpk_tick (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  output logic tick_o
);
  localparam int unsigned TickMax = `FPK_TICK_CYCLES - 1;
  logic [16:0] cnt_reg;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= 17'h0_0000;
      tick_o <= 1'b0;
    end else if (cnt_reg == 17'(TickMax)) begin
      cnt_reg <= 17'h0_0000;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 17'h0_0001;
      tick_o <= 1'b0;
    end
  end
endmodule // fpk_tick
